// [src/tmf_top.sv]
// Purpose: Temperature measurement sequencing, averaging and formatting
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   Tags mark where each rule is carried out
// Operation
// - Configuration two bit 7 routes analog inputs to a second remote diode.
// - Configuration three bits 6 and 7 switch analog channels to thermistors; the code does so only while configuration two bit 7 is clear.
// - Excite base then first multiple, then base then second multiple.
// - Temperature computed from the two delta readings together.
// - Sixteen measurement cycles averaged before a result is stored.
// - Local sensor runs through the same excitation and averaging path.
// - Result high byte weighs one degree per step.
// - Two quarter-degree bits sit in a separate extension register.
// - Plain binary code equals degrees, zero to 127; the code gives zero for anything below one degree.
// - Configuration one bit 7 selects range for all channels.
// - Plain binary reports zero at or below zero degrees.
// - Remote fraction in extension one bits 1:0, local in extension two.
`timescale 1ns/1ps
`include "tmf_map.svh"
module tmf_top #(
    parameter int SETTLE_CYC = `TMF_SETTLE_CYC,
    parameter int AVG_COUNT  = `TMF_AVG_COUNT
) (
    // AHB-Lite
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // Converter
    input  wire logic               adc_valid,
    input  wire logic [15:0]        adc_data,
    output logic                    adc_start,
    output tmf_pkg::tmf_current_type current_sel,
    output tmf_pkg::tmf_source_type  source_sel,
    // Analog pin routing
    output logic                    pins_second_diode,
    output logic                    therm_one_en,
    output logic                    therm_two_en
);

    // ****************************************
    // Bus slave
    // ****************************************
    logic [7:0]  cfg_one, next_cfg_one;
    logic [7:0]  cfg_two, next_cfg_two;
    logic [7:0]  cfg_three, next_cfg_three;
    logic        ph_wr, next_ph_wr;
    logic [7:0]  ph_idx, next_ph_idx;
    logic [31:0] next_hrdata;
    tmf_pkg::tmf_result_type res_remote, res_local, res_second;
    logic [7:0]  meas_count;

    function automatic logic [31:0] read_reg(input logic [7:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (idx)
            `TMF_IDX_CFG_ONE:     v[7:0] = cfg_one;
            `TMF_IDX_CFG_TWO:     v[7:0] = cfg_two;
            `TMF_IDX_CFG_THREE:   v[7:0] = cfg_three;
            `TMF_IDX_REMOTE_TEMP: v[7:0] = res_remote.high;
            `TMF_IDX_LOCAL_TEMP:  v[7:0] = res_local.high;
            `TMF_IDX_SECOND_TEMP: v[7:0] = res_second.high;
            `TMF_IDX_EXT_ONE:     v[1:0] = res_remote.frac;
            `TMF_IDX_EXT_TWO:     v[1:0] = res_local.frac;
            `TMF_IDX_STATUS:      v[7:0] = meas_count;
            default:              v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_reg

    always_comb begin
        next_ph_wr     = 1'b0;
        next_ph_idx    = ph_idx;
        next_cfg_one   = cfg_one;
        next_cfg_two   = cfg_two;
        next_cfg_three = cfg_three;
        next_hrdata    = hrdata;
        if (hsel && hready && htrans[1]) begin
            next_ph_wr  = hwrite;
            next_ph_idx = haddr[9:2];
            if (!hwrite) begin
                next_hrdata = read_reg(haddr[9:2]);
            end
        end
        if (ph_wr) begin
            unique case (ph_idx)
                `TMF_IDX_CFG_ONE:   next_cfg_one   = hwdata[7:0];
                `TMF_IDX_CFG_TWO:   next_cfg_two   = hwdata[7:0];
                `TMF_IDX_CFG_THREE: next_cfg_three = hwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_one   <= `TMF_RST_CFG;
            cfg_two   <= `TMF_RST_CFG;
            cfg_three <= `TMF_RST_CFG_THREE;
            ph_wr     <= 1'b0;
            ph_idx    <= 8'h00;
            hrdata    <= 32'h0000_0000;
        end else begin
            cfg_one   <= next_cfg_one;
            cfg_two   <= next_cfg_two;
            cfg_three <= next_cfg_three;
            ph_wr     <= next_ph_wr;
            ph_idx    <= next_ph_idx;
            hrdata    <= next_hrdata;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ****************************************
    // Source routing
    // ****************************************
    logic range_ext;
    assign range_ext         = cfg_one[`TMF_BIT_RANGE_EXT];
    assign pins_second_diode = cfg_two[`TMF_BIT_SECOND_DIODE];
    assign therm_one_en      = !pins_second_diode && cfg_three[`TMF_BIT_THERM_ONE];
    assign therm_two_en      = !pins_second_diode && cfg_three[`TMF_BIT_THERM_TWO];

    // ****************************************
    // Measurement sequencer
    // ****************************************
    tmf_pkg::tmf_source_type src, next_src;
    logic        exc_start, next_exc_start;
    logic        exc_busy;
    tmf_pkg::tmf_delta_type delta;
    logic [4:0]  avg_cnt, next_avg_cnt;
    logic signed [21:0] acc, next_acc;
    logic signed [17:0] sample;
    logic signed [11:0] avg_q;
    tmf_pkg::tmf_result_type fmt;
    tmf_pkg::tmf_result_type next_res_remote, next_res_local, next_res_second;
    logic [7:0]  next_meas_count;

    tmf_excite #(
        .SETTLE_CYC (SETTLE_CYC)
    ) tmf_excite_inst (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .start       (exc_start),
        .current_sel (current_sel),
        .busy        (exc_busy),
        .adc_valid   (adc_valid),
        .adc_data    (adc_data),
        .adc_start   (adc_start),
        .delta       (delta)
    );

    // Temperature from both deltas: 2*d1 - d2 cancels the series term
    assign sample = 18'(signed'({2'b00, delta.delta_one}) * 2)
                  - signed'({2'b00, delta.delta_two});
    assign avg_q  = 12'(acc >>> `TMF_AVG_SHIFT);

    tmf_format tmf_format_inst (
        .quarter_deg (avg_q),
        .range_ext   (range_ext),
        .result      (fmt)
    );

    function automatic tmf_pkg::tmf_source_type next_source(
        input tmf_pkg::tmf_source_type cur, input logic second);
        tmf_pkg::tmf_source_type n;
        n = tmf_pkg::TMF_SRC_LOCAL;
        unique case (cur)
            tmf_pkg::TMF_SRC_LOCAL:  n = tmf_pkg::TMF_SRC_REMOTE;
            tmf_pkg::TMF_SRC_REMOTE: n = second ? tmf_pkg::TMF_SRC_SECOND
                                                : tmf_pkg::TMF_SRC_LOCAL;
            default:                 n = tmf_pkg::TMF_SRC_LOCAL;
        endcase
        return n;
    endfunction : next_source

    always_comb begin
        next_src        = src;
        next_exc_start  = 1'b0;
        next_avg_cnt    = avg_cnt;
        next_acc        = acc;
        next_res_remote = res_remote;
        next_res_local  = res_local;
        next_res_second = res_second;
        next_meas_count = meas_count;
        if (avg_cnt == 5'(AVG_COUNT)) begin
            unique case (src)
                tmf_pkg::TMF_SRC_REMOTE: next_res_remote = fmt;
                tmf_pkg::TMF_SRC_SECOND: next_res_second = fmt;
                default:                 next_res_local  = fmt;
            endcase
            next_avg_cnt    = 5'h00;
            next_acc        = 22'sh000000;
            next_src        = next_source(src, pins_second_diode);
            next_meas_count = meas_count + 8'h01;
        end else if (delta.valid) begin
            next_acc     = acc + 22'(sample);
            next_avg_cnt = avg_cnt + 5'h01;
        end else if (!exc_busy && !exc_start) begin
            next_exc_start = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src        <= tmf_pkg::TMF_SRC_LOCAL;
            exc_start  <= 1'b0;
            avg_cnt    <= 5'h00;
            acc        <= 22'sh000000;
            res_remote <= '0;
            res_local  <= '0;
            res_second <= '0;
            meas_count <= 8'h00;
        end else begin
            src        <= next_src;
            exc_start  <= next_exc_start;
            avg_cnt    <= next_avg_cnt;
            acc        <= next_acc;
            res_remote <= next_res_remote;
            res_local  <= next_res_local;
            res_second <= next_res_second;
            meas_count <= next_meas_count;
        end
    end

    assign source_sel = src;

    // ****************************************
    // Checks
    // ****************************************
    AST_AVG_STORE: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(meas_count) |-> $past(avg_cnt) == 5'(AVG_COUNT))
        else $error("Result stored without full average");

    AST_PLAIN_CLAMP: assert property (@(posedge hclk) disable iff (!hresetn)
        !range_ext |-> !fmt.high[7])
        else $error("Plain binary result above 127");

    AST_PLAIN_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        !range_ext && avg_q < 12'sh004 |-> fmt == '0)
        else $error("Plain binary not zero at or below zero degrees");

    AST_OFFSET_ADD: assert property (@(posedge hclk) disable iff (!hresetn)
        range_ext && avg_q >= 12'sh000 && avg_q < 12'sh100
        |-> {fmt.high, fmt.frac} == 10'(avg_q + 12'sh100))
        else $error("Offset binary code not shifted by 64");

    AST_PLAIN_EQUAL: assert property (@(posedge hclk) disable iff (!hresetn)
        !range_ext && avg_q >= 12'sh004 && avg_q <= 12'sh1fc
        |-> {fmt.high, fmt.frac} == avg_q[9:0])
        else $error("Plain binary code differs from temperature");

    AST_SECOND_PINS: assert property (@(posedge hclk) disable iff (!hresetn)
        pins_second_diode |-> !therm_one_en && !therm_two_en)
        else $error("Thermistor enabled while second diode selected");

    AST_THERM_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
        !pins_second_diode |-> therm_one_en == cfg_three[7] && therm_two_en == cfg_three[6])
        else $error("Thermistor enable does not follow configuration");

    AST_SRC_SECOND: assert property (@(posedge hclk) disable iff (!hresetn)
        src == tmf_pkg::TMF_SRC_SECOND && $changed(src) |-> $past(pins_second_diode))
        else $error("Second diode measured while pins assigned to analog");

    AST_EXT_REMOTE: assert property (@(posedge hclk) disable iff (!hresetn)
        hsel && hready && htrans[1] && !hwrite && haddr[9:2] == `TMF_IDX_EXT_ONE
        |=> hrdata == {30'h0, $past(res_remote.frac)})
        else $error("Extension one does not show remote fraction");

    AST_RANGE_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
        ph_wr && ph_idx == `TMF_IDX_CFG_ONE |=> range_ext == $past(hwdata[7]))
        else $error("Range select not from configuration one");

    sequence seq_store_remote;
        (avg_cnt == 5'(AVG_COUNT)) && (src == tmf_pkg::TMF_SRC_REMOTE);
    endsequence

    sequence seq_store_local;
        (avg_cnt == 5'(AVG_COUNT)) && (src == tmf_pkg::TMF_SRC_LOCAL);
    endsequence

    AST_STORE_REMOTE: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_store_remote |=> res_remote == $past(fmt))
        else $error("Remote result not stored from formatted average");

    AST_STORE_LOCAL: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_store_local |=> res_local == $past(fmt))
        else $error("Local result not stored from formatted average");

    AST_EXT_LOCAL: assert property (@(posedge hclk) disable iff (!hresetn)
        hsel && hready && htrans[1] && !hwrite && haddr[9:2] == `TMF_IDX_EXT_TWO
        |=> hrdata == {30'h0, $past(res_local.frac)})
        else $error("Extension two does not show local fraction");

    AST_DIODE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        ph_wr && ph_idx == `TMF_IDX_CFG_TWO |=> pins_second_diode == $past(hwdata[7]))
        else $error("Second diode select does not follow configuration two write");

endmodule : tmf_top

// [src/tmf_map.svh]
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AHB-Lite register bus, byte addresses
// Notes:   Printed offsets are not all multiples of four, so they are indexes
`ifndef TMF_MAP_SVH
`define TMF_MAP_SVH

// ****************************************
// Register indexes
// ****************************************
`define TMF_IDX_CFG_ONE      8'h40
`define TMF_IDX_CFG_TWO      8'h01
`define TMF_IDX_CFG_THREE    8'h02
`define TMF_IDX_EXT_ONE      8'h08
`define TMF_IDX_EXT_TWO      8'h09
`define TMF_IDX_REMOTE_TEMP  8'h0d
`define TMF_IDX_LOCAL_TEMP   8'h0e
`define TMF_IDX_SECOND_TEMP  8'h0a
`define TMF_IDX_THERM_TWO    8'h0b
`define TMF_IDX_STATUS       8'h41

// ****************************************
// Field positions
// ****************************************
`define TMF_BIT_RANGE_EXT    7
`define TMF_BIT_SECOND_DIODE 7
`define TMF_BIT_THERM_ONE    7
`define TMF_BIT_THERM_TWO    6

// ****************************************
// Reset values and format constants
// ****************************************
`define TMF_RST_CFG          8'h00
`define TMF_RST_CFG_THREE    8'hc0
`define TMF_OFFSET_CODE      10'h100
`define TMF_PLAIN_MAX        10'h1fc
`define TMF_AVG_COUNT        16
`define TMF_AVG_SHIFT        4

// ****************************************
// Timing
// ****************************************
`define TMF_CLK_MHZ          100
`define TMF_SETTLE_NS        1000
`define TMF_SETTLE_CYC       ((`TMF_SETTLE_NS * `TMF_CLK_MHZ) / 1000)

`endif

// [src/tmf_pkg.sv]
// Purpose: Types shared by the temperature measurement block
// Assumes: Constants live in tmf_map.svh
// Notes:   Quarter-degree codes are 10 bits, signed where noted
package tmf_pkg;

    typedef enum logic [4:0] {
        TMF_IDLE   = 5'b00001,
        TMF_BASE_A = 5'b00010,
        TMF_MULT_A = 5'b00100,
        TMF_BASE_B = 5'b01000,
        TMF_MULT_B = 5'b10000
    } tmf_exc_state_type;

    typedef enum logic [1:0] {
        TMF_CUR_BASE   = 2'h0,
        TMF_CUR_FIRST  = 2'h1,
        TMF_CUR_SECOND = 2'h2
    } tmf_current_type;

    typedef enum logic [1:0] {
        TMF_SRC_LOCAL  = 2'h0,
        TMF_SRC_REMOTE = 2'h1,
        TMF_SRC_SECOND = 2'h2,
        TMF_SRC_THERM  = 2'h3
    } tmf_source_type;

    typedef struct packed {
        logic [7:0] high;
        logic [1:0] frac;
    } tmf_result_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] delta_one;
        logic [15:0] delta_two;
    } tmf_delta_type;

endpackage : tmf_pkg

// [src/tmf_excite.sv]
// Purpose: Three-current excitation sequencer for one diode measurement
// Assumes: ADC sample arrives with adc_valid after each settle period
// Notes:   Delta pairs are taken as multiple reading minus base reading
`timescale 1ns/1ps
`include "tmf_map.svh"
module tmf_excite #(
    parameter int SETTLE_CYC = `TMF_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // Control
    input  wire logic                   start,
    output tmf_pkg::tmf_current_type    current_sel,
    output logic                        busy,
    // Converter
    input  wire logic                   adc_valid,
    input  wire logic [15:0]            adc_data,
    output logic                        adc_start,
    // Result
    output tmf_pkg::tmf_delta_type      delta
);

    // ****************************************
    // Sequencer
    // ****************************************
    tmf_pkg::tmf_exc_state_type state, next_state;
    logic [15:0]                base_val, next_base_val;
    tmf_pkg::tmf_delta_type     next_delta;
    logic [15:0]                wait_cnt, next_wait_cnt;
    logic                       next_adc_start;
    logic                       waiting, next_waiting;

    always_comb begin
        next_state     = state;
        next_base_val  = base_val;
        next_delta     = delta;
        next_delta.valid = 1'b0;
        next_wait_cnt  = wait_cnt;
        next_adc_start = 1'b0;
        next_waiting   = waiting;
        if (waiting) begin
            if (wait_cnt != 16'h0000) begin
                next_wait_cnt = wait_cnt - 16'h0001;
            end else begin
                next_adc_start = 1'b1;
                next_waiting   = 1'b0;
            end
        end
        unique case (state)
            tmf_pkg::TMF_IDLE: begin
                if (start) begin
                    next_state    = tmf_pkg::TMF_BASE_A;
                    next_waiting  = 1'b1;
                    next_wait_cnt = 16'(SETTLE_CYC - 1);
                end
            end
            tmf_pkg::TMF_BASE_A, tmf_pkg::TMF_MULT_A,
            tmf_pkg::TMF_BASE_B, tmf_pkg::TMF_MULT_B: begin
                if (adc_valid && !waiting) begin
                    next_waiting  = 1'b1;
                    next_wait_cnt = 16'(SETTLE_CYC - 1);
                    unique case (state)
                        tmf_pkg::TMF_BASE_A: begin
                            next_base_val = adc_data;
                            next_state    = tmf_pkg::TMF_MULT_A;
                        end
                        tmf_pkg::TMF_MULT_A: begin
                            next_delta.delta_one = adc_data - base_val;
                            next_state           = tmf_pkg::TMF_BASE_B;
                        end
                        tmf_pkg::TMF_BASE_B: begin
                            next_base_val = adc_data;
                            next_state    = tmf_pkg::TMF_MULT_B;
                        end
                        default: begin
                            next_delta.delta_two = adc_data - base_val;
                            next_delta.valid     = 1'b1;
                            next_state           = tmf_pkg::TMF_IDLE;
                            next_waiting         = 1'b0;
                        end
                    endcase
                end
            end
            default: begin
                next_state   = tmf_pkg::TMF_IDLE;
                next_waiting = 1'b0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= tmf_pkg::TMF_IDLE;
            base_val  <= 16'h0000;
            delta     <= '0;
            wait_cnt  <= 16'h0000;
            adc_start <= 1'b0;
            waiting   <= 1'b0;
        end else begin
            state     <= next_state;
            base_val  <= next_base_val;
            delta     <= next_delta;
            wait_cnt  <= next_wait_cnt;
            adc_start <= next_adc_start;
            waiting   <= next_waiting;
        end
    end

    // ****************************************
    // Current selection
    // ****************************************
    always_comb begin
        unique case (state)
            tmf_pkg::TMF_MULT_A: current_sel = tmf_pkg::TMF_CUR_FIRST;
            tmf_pkg::TMF_MULT_B: current_sel = tmf_pkg::TMF_CUR_SECOND;
            default:             current_sel = tmf_pkg::TMF_CUR_BASE;
        endcase
    end

    assign busy = (state != tmf_pkg::TMF_IDLE);

    // ****************************************
    // Checks
    // ****************************************
    sequence seq_take_base_a;
        (state == tmf_pkg::TMF_BASE_A) && adc_valid && !waiting;
    endsequence

    sequence seq_first_current;
        (current_sel == tmf_pkg::TMF_CUR_FIRST) && waiting;
    endsequence

    AST_FIRST_AFTER_BASE: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_take_base_a |=> seq_first_current)
        else $error("First multiple current not applied after base sample");

    AST_ORDER_AFTER_FIRST: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == tmf_pkg::TMF_MULT_A) && $changed(state) |-> $past(state) == tmf_pkg::TMF_BASE_A)
        else $error("First multiple not preceded by base current");

    AST_ORDER_SECOND: assert property (@(posedge hclk) disable iff (!hresetn)
        (state == tmf_pkg::TMF_MULT_B) && $changed(state) |-> $past(state) == tmf_pkg::TMF_BASE_B)
        else $error("Second multiple not preceded by base current");

endmodule : tmf_excite

// [src/tmf_format.sv]
// Purpose: Averaged quarter-degree value to stored result code
// Assumes: Input is signed quarter degrees
// Notes:   Plain binary clamps to 0..127, offset binary adds 64
`timescale 1ns/1ps
`include "tmf_map.svh"
module tmf_format (
    // Value
    input  wire logic signed [11:0]     quarter_deg,
    input  wire logic                   range_ext,
    // Result
    output tmf_pkg::tmf_result_type     result
);

    logic signed [11:0] shifted;
    logic        [9:0]  code;

    always_comb begin
        shifted = quarter_deg;
        if (range_ext) begin
            shifted = quarter_deg + 12'sh100;
        end
        if (shifted < 12'sh000) begin
            code = 10'h000;
        end else if (!range_ext && shifted > 12'sh1fc) begin
            code = `TMF_PLAIN_MAX;
        end else if (shifted > 12'sh3ff) begin
            code = 10'h3ff;
        end else begin
            code = shifted[9:0];
        end
        if (!range_ext && shifted < 12'sh004) begin
            code = 10'h000;
        end
        result.high = code[9:2];
        result.frac = code[1:0];
    end

endmodule : tmf_format

// [tb/tmf_diode_model.sv]
// Purpose: Remote diode and converter model answering each conversion request
// Assumes: Readings are 0x8000 plus quarters on either multiple current
// Notes:   Latency alternates between prompt and slow; data inverts when released
`timescale 1ns/1ps
module tmf_diode_model (
    // Clock
    input  wire logic                hclk,
    // Converter
    input  wire logic                adc_start,
    input  tmf_pkg::tmf_current_type current_sel,
    input  wire logic [15:0]         quarters,
    output logic                     adc_valid,
    output logic [15:0]              adc_data
);
    int   wait_n = 0;
    logic slow   = 1'b0;
    initial begin
        adc_valid = 1'b0;
        adc_data  = 16'h0000;
    end
    always @(posedge hclk) begin
        adc_valid <= 1'b0;
        if (wait_n == 1) begin
            adc_valid <= 1'b1;
            adc_data  <= 16'h8000 + ((current_sel != tmf_pkg::TMF_CUR_BASE) ? quarters : 16'h0);
        end else if (adc_valid) begin
            adc_data <= ~adc_data;
        end
        if (wait_n != 0) wait_n <= wait_n - 1;
        if (adc_start) begin
            wait_n <= slow ? 4 : 1;
            slow   <= !slow;
        end
    end
endmodule : tmf_diode_model

// [tb/temp_measure_format_bench.sv]
// Purpose: Self-checking bench for the measurement and format block
// Assumes: Zero wait state slave, shortened settle count
// Notes:   Each value set by meas is held for more than four full source rotations before reading
`timescale 1ns/1ps
`include "tmf_map.svh"
module temp_measure_format_bench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [15:0] quarters = 16'h0, adc_data;
    logic        hreadyout, hresp, adc_valid, adc_start, second, th1, th2;
    tmf_pkg::tmf_current_type current_sel;
    tmf_pkg::tmf_source_type  src_sel;
    int err_total = 0, samples_checked = 0;
    always #5 hclk = ~hclk;
    tmf_top #(.SETTLE_CYC(2), .AVG_COUNT(16)) tmf_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .adc_valid(adc_valid),
        .adc_data(adc_data), .adc_start(adc_start), .current_sel(current_sel),
        .source_sel(src_sel), .pins_second_diode(second), .therm_one_en(th1), .therm_two_en(th2));
    tmf_diode_model tmf_diode_model_inst (.hclk(hclk), .adc_start(adc_start),
        .current_sel(current_sel), .quarters(quarters), .adc_valid(adc_valid),
        .adc_data(adc_data));
    task end_of_test;
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
        if (n >= 50) begin
            err_total++;
            end_of_test();
        end
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 100);
        q = hrdata;
        if (n >= 100) begin
            err_total++;
            end_of_test();
        end
    endtask : bus
    task meas(input logic [15:0] q, input logic ext, input logic [9:0] exp);
        logic [31:0] d;
        quarters <= q;
        bus(1'b1, `TMF_IDX_CFG_ONE, {24'h0, ext, 7'h0}, d);
        repeat (4000) @(posedge hclk);
        bus(1'b0, `TMF_IDX_REMOTE_TEMP, 32'h0, d);
        chk(d, {24'h0, exp[9:2]});
        bus(1'b0, `TMF_IDX_EXT_ONE, 32'h0, d);
        chk(d, {30'h0, exp[1:0]});
        bus(1'b0, `TMF_IDX_LOCAL_TEMP, 32'h0, d);
        chk(d, {24'h0, exp[9:2]});
        bus(1'b0, `TMF_IDX_EXT_TWO, 32'h0, d);
        chk(d, {30'h0, exp[1:0]});
    endtask : meas
    task test_cfg;
        logic [31:0] d;
        int n;
        n = 0;
        bus(1'b0, `TMF_IDX_CFG_THREE, 32'h0, d);
        chk(d, 32'hc0);
        chk({th1, th2, second}, 3'b110);
        bus(1'b1, `TMF_IDX_CFG_THREE, 32'h40, d);
        bus(1'b0, `TMF_IDX_CFG_THREE, 32'h0, d);
        chk(d, 32'h40);
        chk({th1, th2, second}, 3'b010);
        quarters <= 16'd102;
        bus(1'b1, `TMF_IDX_CFG_TWO, 32'h80, d);
        bus(1'b0, `TMF_IDX_CFG_TWO, 32'h0, d);
        chk(d, 32'h80);
        chk({th1, th2, second}, 3'b001);
        while (src_sel !== tmf_pkg::TMF_SRC_SECOND && n < 4000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 4000) begin
            err_total++;
            end_of_test();
        end
        chk(src_sel, tmf_pkg::TMF_SRC_SECOND);
        repeat (2000) @(posedge hclk);
        bus(1'b0, `TMF_IDX_SECOND_TEMP, 32'h0, d);
        chk(d, 32'h19);
        bus(1'b1, `TMF_IDX_CFG_TWO, 32'h0, d);
        $display("test_cfg done");
    endtask : test_cfg
    task test_plain;
        meas(16'd102, 1'b0, 10'h066);
        meas(-16'sd20, 1'b0, 10'h000);
        meas(16'd800, 1'b0, 10'h1fc);
        $display("test_plain done");
    endtask : test_plain
    task test_ext;
        meas(16'd102, 1'b1, 10'h166);
        meas(-16'sd256, 1'b1, 10'h000);
        meas(16'd767, 1'b1, 10'h3ff);
        $display("test_ext done");
    endtask : test_ext
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_cfg();
        test_plain();
        test_ext();
        end_of_test();
    end
endmodule : temp_measure_format_bench
